// file: hw/link_regs_map.svh
`ifndef LINK_REGS_MAP_SVH
`define LINK_REGS_MAP_SVH

// Configuration offsets (byte addresses, 16-bit registers)
`define LINK_CTRL_OFS 8'ha0
`define LINK_STAT_OFS 8'ha2

// Reset values
`define LINK_CTRL_RESET 16'h0000
`define LINK_STAT_RESET 16'h1011
`define ASPM_RESET 2'h0
`define CB_RESET 1'h0

// Link control field positions
`define CTRL_ASPM_LSB 0
`define CTRL_ASPM_MSB 1
`define CTRL_RSVD_BIT 2
`define CTRL_CB_BIT 3
`define CTRL_OFF_BIT 4

// Link status field positions and constant contents
`define STAT_SPEED_LSB 0
`define STAT_SPEED_MSB 3
`define STAT_WIDTH_LSB 4
`define STAT_WIDTH_MSB 9
`define STAT_RETRAIN_BIT 10
`define STAT_TRAIN_BIT 11
`define STAT_SLOTCLK_BIT 12
`define STAT_RSVD_LSB 13
`define STAT_RSVD_MSB 15
`define STAT_SPEED_VAL 4'h1
`define STAT_WIDTH_VAL 6'h01
`define STAT_SLOTCLK_VAL 1'h1

// Active-state PM encodings
`define ASPM_L0S_BIT 0
`define ASPM_L1_BIT 1

// Completion boundary the bridge actually uses, in bytes
`define FIXED_CB_BYTES 8'h80

`endif

// file: hw/link_regs_pkg.sv
package link_regs_pkg;

  typedef logic [1:0] aspm_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic ack;
    logic l0s_go;
    logic l1_go;
    logic refclk_fault;
  } link_regs_state_t;

endpackage

// file: hw/cfg_sync2.sv
`timescale 1ns/100ps

module cfg_sync2 (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Asynchronous level in, synchronised level out
  input wire logic async_i,
  output logic sync_o
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  always_comb begin
    state_next.meta = async_i;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stable;

endmodule

// file: hw/cfg_field_reg.sv
`timescale 1ns/100ps

module cfg_field_reg #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Write side
  input wire logic wr_en_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // Stored value
  output logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] value;
  } field_state_t;

  field_state_t state_reg;
  field_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (wr_en_i) begin
      state_next.value = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg.value <= RESET_VAL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q_o = state_reg.value;

endmodule

// file: hw/pcie_link_ctrl_status_regs.sv
// Behaviour
// - Link-off bit does nothing, reads zero
// - Bit 3 stores root boundary, 0=64 default
// - Boundary bit never changes bridge; fixed 128
// - Control bit 2 reserved, reads zero
// - Bits 1:0 gate L0s/L1 entry, default off
// - Status read-only at A2h, reset 1011h
// - Status bits 15:13 reserved, read zero
// - Status bit 12 reads one, common clock
// - Training flag does nothing, reads zero
// - Retrain flag does nothing, reads zero
// - Width field constant 000001b, single lane
// - Speed field constant 1h, 2.5 Gb/s
// - Link control resets to all zeros
`include "link_regs_map.svh"
`timescale 1ns/100ps

module pcie_link_ctrl_status_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Configuration access port
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [1:0] cfg_be_i,
  input wire logic [15:0] cfg_wdata_i,
  output logic [15:0] cfg_rdata_o,
  output logic cfg_ack_o,
  // Power-management entry requests from the link core
  input wire logic l0s_entry_req_i,
  input wire logic l1_entry_req_i,
  output logic l0s_entry_go_o,
  output logic l1_entry_go_o,
  // Link control state seen by the core
  output link_regs_pkg::aspm_t active_pm_ctrl_o,
  output logic completion_boundary_sel_o,
  output logic [7:0] completion_bytes_o,
  // Board reference-clock select pin
  input wire logic refclk_choice_i,
  output logic refclk_fault_o
);

  link_regs_pkg::link_regs_state_t state_reg;
  link_regs_pkg::link_regs_state_t state_next;

  logic hit_ctrl;
  logic hit_stat;
  logic ctrl_low_wr;
  logic refclk_choice_sync;
  link_regs_pkg::aspm_t active_pm_ctrl;
  logic completion_boundary_sel;
  logic [15:0] link_control;
  logic [15:0] link_status;

  // Word-aligned decode; address bit 0 is ignored
  assign hit_ctrl = (cfg_addr_i[7:1] == 7'(`LINK_CTRL_OFS >> 1));
  assign hit_stat = (cfg_addr_i[7:1] == 7'(`LINK_STAT_OFS >> 1));
  // only low byte holds writable bits
  assign ctrl_low_wr = cfg_wr_i && hit_ctrl && cfg_be_i[0];

  cfg_field_reg #(
    .WIDTH(2),
    .RESET_VAL(`ASPM_RESET)
  ) u_aspm (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .wr_en_i(ctrl_low_wr),
    .wdata_i(cfg_wdata_i[`CTRL_ASPM_MSB:`CTRL_ASPM_LSB]),
    .q_o(active_pm_ctrl)
  );

  cfg_field_reg #(
    .WIDTH(1),
    .RESET_VAL(`CB_RESET)
  ) u_cb (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .wr_en_i(ctrl_low_wr),
    .wdata_i(cfg_wdata_i[`CTRL_CB_BIT]),
    .q_o(completion_boundary_sel)
  );

  // Pin from the board crosses in through two flops
  cfg_sync2 u_refclk_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i(refclk_choice_i),
    .sync_o(refclk_choice_sync)
  );

  always_comb begin
    link_control = 16'h0000;
    link_control[`CTRL_OFF_BIT] = 1'b0;
    link_control[`CTRL_RSVD_BIT] = 1'b0;
    link_control[`CTRL_CB_BIT] = completion_boundary_sel;
    link_control[`CTRL_ASPM_MSB:`CTRL_ASPM_LSB] = active_pm_ctrl;
  end

  always_comb begin
    link_status = 16'h0000;
    link_status[`STAT_RSVD_MSB:`STAT_RSVD_LSB] = 3'h0;
    link_status[`STAT_SLOTCLK_BIT] = `STAT_SLOTCLK_VAL;
    link_status[`STAT_TRAIN_BIT] = 1'b0;
    link_status[`STAT_RETRAIN_BIT] = 1'b0;
    link_status[`STAT_WIDTH_MSB:`STAT_WIDTH_LSB] = `STAT_WIDTH_VAL;
    link_status[`STAT_SPEED_MSB:`STAT_SPEED_LSB] = `STAT_SPEED_VAL;
  end

  always_comb begin
    state_next = state_reg;
    state_next.ack = cfg_wr_i || cfg_rd_i;
    // Write wins if both strobes arrive together
    if (cfg_rd_i && !cfg_wr_i) begin
      if (hit_ctrl) begin
        state_next.rdata = link_control;
      end else if (hit_stat) begin
        state_next.rdata = link_status;
      end else begin
        state_next.rdata = 16'h0000;
      end
    end
    state_next.l0s_go = l0s_entry_req_i && active_pm_ctrl[`ASPM_L0S_BIT];
    state_next.l1_go = l1_entry_req_i && active_pm_ctrl[`ASPM_L1_BIT];
    state_next.refclk_fault = refclk_choice_sync;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cfg_rdata_o = state_reg.rdata;
  assign cfg_ack_o = state_reg.ack;
  assign l0s_entry_go_o = state_reg.l0s_go;
  assign l1_entry_go_o = state_reg.l1_go;
  assign refclk_fault_o = state_reg.refclk_fault;
  assign active_pm_ctrl_o = active_pm_ctrl;
  assign completion_boundary_sel_o = completion_boundary_sel;
  // bridge boundary fixed, ignores bit 3
  assign completion_bytes_o = `FIXED_CB_BYTES;

endmodule

// file: tb/link_regs_monitor.sv
`timescale 1ns/100ps
module link_regs_monitor (
  // Clock, reset and access port
  input wire logic clk_i, srst_i, cfg_wr_i, cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [1:0] cfg_be_i,
  input wire logic [15:0] cfg_wdata_i, cfg_rdata_o,
  input wire logic cfg_ack_o,
  // Power-management gate and link control
  input wire logic l0s_entry_req_i, l1_entry_req_i,
  input wire logic l0s_entry_go_o, l1_entry_go_o,
  input wire link_regs_pkg::aspm_t active_pm_ctrl_o,
  input wire logic completion_boundary_sel_o,
  input wire logic [7:0] completion_bytes_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire logic cw = cfg_wr_i && cfg_addr_i[7:1] == 7'h50 && cfg_be_i[0];
  // Reads that share a cycle with a write leave rdata alone
  wire logic rc = cfg_rd_i && !cfg_wr_i && cfg_addr_i[7:1] == 7'h50;
  wire logic rs = cfg_rd_i && !cfg_wr_i && cfg_addr_i[7:1] == 7'h51;
  wire logic [2:0] wf = {cfg_wdata_i[3], cfg_wdata_i[1:0]};
  wire logic [2:0] cs = {completion_boundary_sel_o, active_pm_ctrl_o};
  wire logic g0 = l0s_entry_req_i && active_pm_ctrl_o[0];
  wire logic g1 = l1_entry_req_i && active_pm_ctrl_o[1];
  a_ack_per_access:
    assert property ((cfg_wr_i || cfg_rd_i) |=> cfg_ack_o) else $error("No ack");
  a_status_const:
    assert property (rs |=> cfg_rdata_o == 16'h1011) else $error("Bad status");
  a_ctrl_zeros:
    assert property (rc |=> cfg_rdata_o[15:4] == 12'h000 && !cfg_rdata_o[2])
    else $error("Control zeros");
  a_ctrl_mirror:
    assert property (rc |=> {cfg_rdata_o[3], cfg_rdata_o[1:0]} == cs)
    else $error("Control readback");
  a_ctrl_write:
    assert property (cw |=> cs == $past(wf)) else $error("Write lost");
  a_ctrl_hold:
    assert property (!cw |=> $stable(cs)) else $error("Control moved");
  a_ctrl_reset:
    assert property ($fell(srst_i) |-> cs == 3'h0) else $error("Reset value");
  a_bytes_fixed:
    assert property (completion_bytes_o == 8'h80) else $error("Boundary moved");
  a_l0s_gate:
    assert property (1'b1 |=> l0s_entry_go_o == $past(g0)) else $error("L0s");
  a_l1_gate:
    assert property (1'b1 |=> l1_entry_go_o == $past(g1)) else $error("L1");
endmodule
bind pcie_link_ctrl_status_regs link_regs_monitor i_mon (.clk_i, .srst_i,
  .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o,
  .cfg_ack_o, .l0s_entry_req_i, .l1_entry_req_i, .l0s_entry_go_o,
  .l1_entry_go_o, .active_pm_ctrl_o, .completion_boundary_sel_o,
  .completion_bytes_o);

// file: tb/pcie_link_ctrl_status_regs_test.sv
`timescale 1ns/100ps
module pcie_link_ctrl_status_regs_test;
  logic clk_i = 0, srst_i = 1, cfg_wr_i = 0, cfg_rd_i = 0;
  logic [7:0] cfg_addr_i = 8'h00, cb_bytes;
  logic [1:0] cfg_be_i = 2'h0;
  logic [15:0] cfg_wdata_i = 16'h0000, cfg_rdata_o, ctrl, d;
  logic cfg_ack_o, l0s_req = 0, l1_req = 0, l0s_go, l1_go, cb, fault;
  link_regs_pkg::aspm_t pm;
  int errors = 0, samples_checked = 0, cyc = 0;
  // board keeps the clock select low
  pcie_link_ctrl_status_regs i_pcie_link_ctrl_status_regs (.clk_i, .srst_i,
    .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o,
    .cfg_ack_o, .l0s_entry_req_i(l0s_req), .l1_entry_req_i(l1_req),
    .l0s_entry_go_o(l0s_go), .l1_entry_go_o(l1_go), .active_pm_ctrl_o(pm),
    .completion_boundary_sel_o(cb), .completion_bytes_o(cb_bytes),
    .refclk_choice_i(1'b0), .refclk_fault_o(fault));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end
  task stop_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [1:0] be,
      input logic [15:0] dt);
    @(posedge clk_i);
    #1;
    {cfg_wr_i, cfg_rd_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = {w, !w, a, be, dt};
    @(posedge clk_i);
    #1;
    {cfg_wr_i, cfg_rd_i} = 2'h0;
    chk(16'(cfg_ack_o), 16'h0001);
  endtask
  initial begin
    void'($urandom(17));
    repeat (2) @(posedge clk_i);
    #1 srst_i = 0;
    acc(0, 8'ha0, 2'h0, 16'h0000);
    chk(cfg_rdata_o, 16'h0000);
    acc(0, 8'hb0, 2'h0, 16'h0000);
    chk(cfg_rdata_o, 16'h0000);
    ctrl = 16'h0000;
    for (int i = 0; i < 40; i++) begin
      d = 16'($urandom);
      // Early passes set every reserved bit
      if (i < 4) d = 16'hfff4 | 16'(i);
      acc(1, 8'ha0, d[5:4], d);
      if (d[4]) ctrl = d & 16'h000b;
      chk(16'({cb, pm}), 16'({ctrl[3], ctrl[1:0]}));
      chk(16'(cb_bytes), 16'h0080);
      acc(0, 8'ha0, 2'h0, 16'h0000);
      chk(cfg_rdata_o, ctrl);
      acc(1, 8'ha2, 2'h3, ~d);
      acc(0, 8'ha2, 2'h0, 16'h0000);
      chk(cfg_rdata_o, 16'h1011);
      {l1_req, l0s_req} = d[7:6];
      @(posedge clk_i);
      #1;
      chk(16'({l1_go, l0s_go}), 16'(d[7:6] & ctrl[1:0]));
      chk(16'(fault), 16'h0000);
    end
    acc(0, 8'ha3, 2'h0, 16'h0000);
    chk(cfg_rdata_o, 16'h1011);
    acc(0, 8'hb0, 2'h0, 16'h0000);
    chk(cfg_rdata_o, 16'h0000);
    acc(1, 8'ha0, 2'h1, 16'h000b);
    srst_i = 1;
    repeat (2) @(posedge clk_i);
    #1 srst_i = 0;
    acc(0, 8'ha0, 2'h0, 16'h0000);
    chk(cfg_rdata_o, 16'h0000);
    stop_test();
  end
endmodule
